// File: pkg/scan_stats_params.svh
// Constants for the scan statistics command unit.
// Assumes inclusion by bare name from design and bench files.
`ifndef SCAN_STATS_PARAMS_SVH
`define SCAN_STATS_PARAMS_SVH

`define NUM_CH 8
`define CH_IDX_W 3
`define SAMPLE_W 16
`define SUM_W 32
`define SQ_W 48
`define CNT_W 16
`define RES_W 32
`define PARAM_W 32
`define MEM_DEPTH 32
`define MEM_IDX_W 5
`define DIV_STEPS 7'h40
`define SQRT_STEPS 6'h20
`define NUM_STD 8
`define STD_V0 32'h0000_000a
`define STD_V1 32'h0000_0064
`define STD_V2 32'h0000_03e8
`define STD_V3 32'h0000_2710
`define STD_V4 32'h0001_86a0
`define STD_V5 32'h000f_4240
`define STD_V6 32'h0098_9680
`define STD_V7 32'h05f5_e100
`define PARAM_FACTORY 32'h0000_2710
`define SCAN_LIST_RST 8'h00

`endif

// File: pkg/scan_stats_pkg.sv
// Types shared by the scan statistics command unit and its bench.
// Assumes the params header is on the include path.
package scan_stats_pkg;

  typedef enum logic [2:0] {
    OP_ABORT = 3'h0,
    OP_INITIATE = 3'h1,
    OP_FACTORY_RESET = 3'h2,
    OP_PRESET = 3'h3,
    OP_STAT_CLEAR = 3'h4,
    OP_QUERY = 3'h5,
    OP_SET_PARAM = 3'h6,
    OP_SET_SCAN_LIST = 3'h7
  } cmd_op_t;

  typedef enum logic [2:0] {
    STAT_AVERAGE = 3'h0,
    STAT_MAXIMUM = 3'h1,
    STAT_MINIMUM = 3'h2,
    STAT_PEAK_TO_PEAK = 3'h3,
    STAT_STD_DEVIATION = 3'h4,
    STAT_COUNT = 3'h5
  } stat_kind_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_NEXT = 6'b000010,
    ST_PREP = 6'b000100,
    ST_DIV = 6'b001000,
    ST_SQRT = 6'b010000,
    ST_EMIT = 6'b100000
  } query_state_t;

endpackage

// File: core/channel_stats.sv
// Running statistics for one channel: count, sum, sum of squares, max, min, peak-to-peak.
// Assumes samples and clear arrive on the same clock, clear has priority.
`timescale 1ns/1ps
`default_nettype none
`include "scan_stats_params.svh"

module channel_stats (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic signed [`SAMPLE_W-1:0] sample,
  output logic [`CNT_W-1:0] count_q,
  output logic signed [`SUM_W-1:0] sum_q,
  output logic [`SQ_W-1:0] sumsq_q,
  output logic signed [`SAMPLE_W-1:0] max_q,
  output logic signed [`SAMPLE_W-1:0] min_q,
  output logic signed [`SAMPLE_W:0] ptp_q
);
  wire logic first = (count_q == '0);
  wire logic signed [`SAMPLE_W-1:0] max_d = (first || sample > max_q) ? sample : max_q;
  wire logic signed [`SAMPLE_W-1:0] min_d = (first || sample < min_q) ? sample : min_q;
  wire logic signed [2*`SAMPLE_W-1:0] sq = sample * sample;

  always_ff @(posedge clock) begin
    if (!rst_b || clear) begin
      count_q <= '0;
      sum_q <= '0;
      sumsq_q <= '0;
      max_q <= '0;
      min_q <= '0;
      ptp_q <= '0;
    end else if (sample_valid) begin
      count_q <= count_q + 16'h0001;
      sum_q <= sum_q + `SUM_W'(sample);
      sumsq_q <= sumsq_q + `SQ_W'(unsigned'(sq));
      max_q <= max_d;
      min_q <= min_d;
      ptp_q <= (`SAMPLE_W+1)'(max_d) - (`SAMPLE_W+1)'(min_d);
    end
  end

  property p_ptp_tracks;
    @(posedge clock) disable iff (!rst_b)
    (count_q != '0) |-> (ptp_q == (`SAMPLE_W+1)'(max_q) - (`SAMPLE_W+1)'(min_q));
  endproperty
  a_ptp_tracks: assert property (p_ptp_tracks) else $error("peak-to-peak differs from max minus min");

  property p_clear_empties;
    @(posedge clock) disable iff (!rst_b)
    clear |=> (count_q == '0 && sum_q == '0 && sumsq_q == '0);
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("statistics survived a clear");

  property p_count_steps;
    @(posedge clock) disable iff (!rst_b)
    (sample_valid && !clear) |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("count did not step on a sample");

endmodule
`default_nettype wire

// File: core/scan_stats_unit.sv
// Command unit: abort, scan start, resets, value snapping and per-channel statistics queries.
// Assumes commands and readings arrive on the same clock, already decoded from text.
`timescale 1ns/1ps
`default_nettype none
`include "scan_stats_params.svh"

module scan_stats_unit (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire scan_stats_pkg::cmd_op_t cmd_op,
  input wire scan_stats_pkg::stat_kind_t cmd_stat,
  input wire logic cmd_sel_given,
  input wire logic [`NUM_CH-1:0] cmd_sel,
  input wire logic [`PARAM_W-1:0] cmd_param,
  input wire logic cmd_round_up,
  input wire logic meter_module_enable,
  input wire logic meter_present,
  input wire logic [`NUM_CH-1:0] channel_kind_ok,
  input wire logic reading_valid,
  input wire logic [`CH_IDX_W-1:0] reading_channel,
  input wire logic signed [`SAMPLE_W-1:0] reading_value,
  output logic cmd_ready_q,
  output logic scan_running_q,
  output logic [`NUM_CH-1:0] scan_list_q,
  output logic [`PARAM_W-1:0] param_q,
  output logic [`MEM_IDX_W:0] stored_count_q,
  output logic resp_valid_q,
  output logic signed [`RES_W-1:0] resp_value_q,
  output logic resp_comma_q,
  output logic resp_last_q,
  output logic error_q
);
  import scan_stats_pkg::*;

  localparam logic [`PARAM_W-1:0] STD_VALUES [`NUM_STD] = '{`STD_V0, `STD_V1, `STD_V2, `STD_V3,
                                                          `STD_V4, `STD_V5, `STD_V6, `STD_V7};

  query_state_t state_q;
  logic [`NUM_CH-1:0] sel_q;
  logic [`CH_IDX_W-1:0] idx_q;
  stat_kind_t stat_q;
  logic any_sent_q;
  logic neg_q;
  logic sqrt_after_q;
  logic [32:0] rem_q;
  logic [63:0] quo_q;
  logic [31:0] den_q;
  logic [6:0] step_q;
  logic [31:0] root_q;
  logic [4:0] bit_q;
  logic signed [`SAMPLE_W-1:0] mem_q [`MEM_DEPTH];

  // Command decode
  wire logic accept = cmd_valid && cmd_ready_q;
  wire logic do_abort = accept && cmd_op == OP_ABORT;
  wire logic do_init = accept && cmd_op == OP_INITIATE;
  wire logic do_factory = accept && cmd_op == OP_FACTORY_RESET;
  wire logic do_preset = accept && cmd_op == OP_PRESET;
  wire logic do_clear = accept && cmd_op == OP_STAT_CLEAR;
  wire logic do_query = accept && cmd_op == OP_QUERY;
  wire logic do_param = accept && cmd_op == OP_SET_PARAM;
  wire logic do_list = accept && cmd_op == OP_SET_SCAN_LIST;
  wire logic stop_scan = do_abort || do_factory || do_preset;
  wire logic stats_clear = do_init || do_clear || do_factory || do_preset;
  wire logic [`NUM_CH-1:0] query_sel = cmd_sel_given ? cmd_sel : scan_list_q;
  wire logic meter_ok = meter_module_enable && meter_present;
  wire logic kind_bad = |(query_sel & ~channel_kind_ok);
  wire logic query_err = !meter_ok || kind_bad;

  // Standard value snapping
  logic [`PARAM_W-1:0] snap_up;
  logic [`PARAM_W-1:0] snap_down;
  always_comb begin
    snap_up = STD_VALUES[`NUM_STD-1];
    snap_down = STD_VALUES[0];
    for (int i = `NUM_STD - 1; i >= 0; i--) begin
      if (STD_VALUES[i] >= cmd_param) begin
        snap_up = STD_VALUES[i];
      end
    end
    for (int i = 0; i < `NUM_STD; i++) begin
      if (STD_VALUES[i] <= cmd_param) begin
        snap_down = STD_VALUES[i];
      end
    end
  end
  wire logic [`PARAM_W-1:0] snapped = cmd_round_up ? snap_up : snap_down;

  // Per-channel statistics
  wire logic sample_take = reading_valid && scan_running_q;
  logic [`CNT_W-1:0] cnt_w [`NUM_CH];
  logic signed [`SUM_W-1:0] sum_w [`NUM_CH];
  logic [`SQ_W-1:0] sq_w [`NUM_CH];
  logic signed [`SAMPLE_W-1:0] max_w [`NUM_CH];
  logic signed [`SAMPLE_W-1:0] min_w [`NUM_CH];
  logic signed [`SAMPLE_W:0] ptp_w [`NUM_CH];
  for (genvar c = 0; c < `NUM_CH; c++) begin : g_ch
    channel_stats u_stats (
      .clock(clock),
      .rst_b(rst_b),
      .clear(stats_clear),
      .sample_valid(sample_take && reading_channel == c),
      .sample(reading_value),
      .count_q(cnt_w[c]),
      .sum_q(sum_w[c]),
      .sumsq_q(sq_w[c]),
      .max_q(max_w[c]),
      .min_q(min_w[c]),
      .ptp_q(ptp_w[c])
    );
  end

  // Lowest selected channel still to answer
  logic [`CH_IDX_W-1:0] low_idx;
  always_comb begin
    low_idx = '0;
    for (int i = `NUM_CH - 1; i >= 0; i--) begin
      if (sel_q[i]) begin
        low_idx = `CH_IDX_W'(i);
      end
    end
  end

  // Operands for the channel being answered
  wire logic [`CNT_W-1:0] c_cnt = cnt_w[idx_q];
  wire logic signed [`SUM_W-1:0] c_sum = sum_w[idx_q];
  wire logic no_data = !scan_list_q[idx_q] || c_cnt == '0;
  wire logic [31:0] sum_mag = c_sum[`SUM_W-1] ? 32'(-c_sum) : 32'(c_sum);
  wire logic [63:0] n_sumsq = 64'(c_cnt) * 64'(sq_w[idx_q]);
  wire logic [63:0] sum_sq = 64'(sum_mag) * 64'(sum_mag);
  wire logic [31:0] n_nm1 = 32'(c_cnt) * 32'(c_cnt - 16'h0001);
  logic signed [`RES_W-1:0] direct_val;
  always_comb begin
    unique case (stat_q)
      STAT_MAXIMUM: direct_val = `RES_W'(max_w[idx_q]);
      STAT_MINIMUM: direct_val = `RES_W'(min_w[idx_q]);
      STAT_PEAK_TO_PEAK: direct_val = `RES_W'(ptp_w[idx_q]);
      default: direct_val = `RES_W'(c_cnt);
    endcase
  end

  // Divider and square root steps
  wire logic [32:0] shifted = {rem_q[31:0], quo_q[63]};
  wire logic fits = shifted >= {1'b0, den_q};
  wire logic [31:0] trial = root_q | (32'h0000_0001 << bit_q);
  wire logic [63:0] trial_sq = 64'(trial) * 64'(trial);
  wire logic [31:0] quo_low = quo_q[31:0];
  wire logic [31:0] avg_mag = (quo_q[63:32] != '0) ? 32'h7fff_ffff : quo_low;

  always_ff @(posedge clock) begin
    if (!rst_b || do_factory) begin
      scan_running_q <= 1'b0;
      scan_list_q <= `SCAN_LIST_RST;
      param_q <= `PARAM_FACTORY;
    end else begin
      if (stop_scan) begin
        scan_running_q <= 1'b0;
      end else if (do_init) begin
        scan_running_q <= 1'b1;
      end
      if (do_list) begin
        scan_list_q <= cmd_sel;
      end
      if (do_param) begin
        param_q <= snapped;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b || do_init || do_factory) begin
      stored_count_q <= '0;
    end else if (sample_take && stored_count_q != (`MEM_IDX_W+1)'(`MEM_DEPTH)) begin
      stored_count_q <= stored_count_q + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (sample_take && stored_count_q != (`MEM_IDX_W+1)'(`MEM_DEPTH)) begin
      mem_q[stored_count_q[`MEM_IDX_W-1:0]] <= reading_value;
    end
  end

  property p_store;
    @(posedge clock) disable iff (!rst_b)
    (sample_take && stored_count_q != (`MEM_IDX_W+1)'(`MEM_DEPTH)) |=>
      (mem_q[$past(stored_count_q[`MEM_IDX_W-1:0])] == $past(reading_value));
  endproperty
  a_store: assert property (p_store) else $error("reading not stored");

  // Query engine runs beside the scan, never touching scan state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      cmd_ready_q <= 1'b1;
      sel_q <= '0;
      idx_q <= '0;
      stat_q <= STAT_AVERAGE;
      any_sent_q <= 1'b0;
      neg_q <= 1'b0;
      sqrt_after_q <= 1'b0;
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      step_q <= '0;
      root_q <= '0;
      bit_q <= '0;
      resp_valid_q <= 1'b0;
      resp_value_q <= '0;
      resp_comma_q <= 1'b0;
      resp_last_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      resp_valid_q <= 1'b0;
      resp_last_q <= 1'b0;
      error_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (do_query && query_err) begin
            error_q <= 1'b1;
          end else if (do_query) begin
            sel_q <= query_sel;
            stat_q <= cmd_stat;
            any_sent_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (sel_q == '0) begin
            cmd_ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            idx_q <= low_idx;
            sel_q[low_idx] <= 1'b0;
            state_q <= ST_PREP;
          end
        end
        ST_PREP: begin
          rem_q <= '0;
          step_q <= '0;
          root_q <= '0;
          bit_q <= 5'h1f;
          if (no_data || (stat_q == STAT_STD_DEVIATION && c_cnt < 16'h0002)) begin
            resp_value_q <= '0;
            den_q <= '0;
            state_q <= ST_EMIT;
          end else if (stat_q == STAT_AVERAGE) begin
            quo_q <= 64'(sum_mag);
            den_q <= 32'(c_cnt);
            neg_q <= c_sum[`SUM_W-1];
            sqrt_after_q <= 1'b0;
            state_q <= ST_DIV;
          end else if (stat_q == STAT_STD_DEVIATION) begin
            quo_q <= n_sumsq - sum_sq;
            den_q <= n_nm1;
            neg_q <= 1'b0;
            sqrt_after_q <= 1'b1;
            state_q <= ST_DIV;
          end else begin
            resp_value_q <= direct_val;
            den_q <= '0;
            state_q <= ST_EMIT;
          end
        end
        ST_DIV: begin
          rem_q <= fits ? shifted - {1'b0, den_q} : shifted;
          quo_q <= {quo_q[62:0], fits};
          step_q <= step_q + 7'h01;
          if (step_q == `DIV_STEPS - 7'h01) begin
            state_q <= sqrt_after_q ? ST_SQRT : ST_EMIT;
          end
          if (step_q == `DIV_STEPS && !sqrt_after_q) begin
            state_q <= ST_EMIT;
          end
        end
        ST_SQRT: begin
          if (trial_sq <= quo_q) begin
            root_q <= trial;
          end
          bit_q <= bit_q - 5'h01;
          if (bit_q == 5'h00) begin
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          // Zero divisor marks a value set in PREP; live counts may move mid-query
          if (den_q != '0 && !sqrt_after_q) begin
            resp_value_q <= neg_q ? -signed'(avg_mag) : signed'(avg_mag);
          end else if (den_q != '0) begin
            resp_value_q <= signed'(root_q);
          end
          resp_valid_q <= 1'b1;
          resp_comma_q <= any_sent_q;
          resp_last_q <= (sel_q == '0);
          any_sent_q <= 1'b1;
          state_q <= ST_NEXT;
        end
        default: begin
          state_q <= ST_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end

  property p_abort_stops;
    @(posedge clock) disable iff (!rst_b)
    (do_abort || do_preset) |=> !scan_running_q;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("scan still running after abort");

  property p_no_resume;
    @(posedge clock) disable iff (!rst_b)
    (!scan_running_q && !do_init) |=> !scan_running_q;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("scan resumed without a new start");

  property p_init_discards;
    @(posedge clock) disable iff (!rst_b)
    do_init |=> (stored_count_q == '0 && cnt_w[0] == '0);
  endproperty
  a_init_discards: assert property (p_init_discards) else $error("readings kept across a new scan");

  property p_abort_keeps;
    @(posedge clock) disable iff (!rst_b)
    (do_abort && !sample_take) |=> (stored_count_q == $past(stored_count_q));
  endproperty
  a_abort_keeps: assert property (p_abort_keeps) else $error("abort discarded readings");

  property p_factory;
    @(posedge clock) disable iff (!rst_b)
    do_factory |=> (scan_list_q == `SCAN_LIST_RST && param_q == `PARAM_FACTORY && !scan_running_q);
  endproperty
  a_factory: assert property (p_factory) else $error("factory reset left state behind");

  property p_preset_keeps_list;
    @(posedge clock) disable iff (!rst_b)
    do_preset |=> $stable(scan_list_q);
  endproperty
  a_preset_keeps_list: assert property (p_preset_keeps_list) else $error("preset changed the scan list");

  property p_snap;
    @(posedge clock) disable iff (!rst_b)
    do_param |=> ($past(cmd_round_up) ? param_q >= $past(cmd_param) || param_q == `STD_V7
                               : param_q <= $past(cmd_param) || param_q == `STD_V0);
  endproperty
  a_snap: assert property (p_snap) else $error("snapped value on wrong side");

  property p_query_error;
    @(posedge clock) disable iff (!rst_b)
    (do_query && !meter_ok) |=> (error_q && !resp_valid_q) ##1 cmd_ready_q;
  endproperty
  a_query_error: assert property (p_query_error) else $error("no error for missing meter module");

  property p_query_no_disturb;
    @(posedge clock) disable iff (!rst_b)
    (!cmd_ready_q && scan_running_q && !stop_scan) |=> scan_running_q;
  endproperty
  a_query_no_disturb: assert property (p_query_no_disturb) else $error("query disturbed the scan");

  property p_absent_zero;
    @(posedge clock) disable iff (!rst_b)
    (state_q == ST_PREP && !scan_list_q[idx_q]) |=> (state_q == ST_EMIT) ##1 (resp_valid_q && resp_value_q == '0);
  endproperty
  a_absent_zero: assert property (p_absent_zero) else $error("absent channel gave nonzero");

  property p_comma;
    @(posedge clock) disable iff (!rst_b)
    (resp_valid_q && !resp_last_q) |-> ##[1:200] (resp_valid_q && resp_comma_q);
  endproperty
  a_comma: assert property (p_comma) else $error("second value lacks separator");

  c_avg_query: cover property (@(posedge clock) disable iff (!rst_b)
    do_query && cmd_stat == STAT_AVERAGE && meter_ok ##[1:120] resp_valid_q);
  c_std_deviation_query_query: cover property (@(posedge clock) disable iff (!rst_b)
    state_q == ST_SQRT ##[1:40] resp_valid_q);
  c_query_in_scan: cover property (@(posedge clock) disable iff (!rst_b)
    scan_running_q && resp_valid_q && resp_last_q);
  c_abort_run: cover property (@(posedge clock) disable iff (!rst_b) scan_running_q && do_abort);

endmodule
`default_nettype wire

// File: verif/host_model.sv
// Host side of the command port: issues commands and gathers query answers.
// Assumes one shared clock and a design that samples on its rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "scan_stats_params.svh"

module host_model
  import scan_stats_pkg::*;
(
  input wire logic clock,
  input wire logic cmd_ready_q,
  input wire logic resp_valid_q,
  input wire logic signed [`RES_W-1:0] resp_value_q,
  input wire logic resp_comma_q,
  input wire logic resp_last_q,
  input wire logic error_q,
  output logic cmd_valid,
  output var scan_stats_pkg::cmd_op_t cmd_op,
  output var scan_stats_pkg::stat_kind_t cmd_stat,
  output logic cmd_sel_given,
  output logic [`NUM_CH-1:0] cmd_sel,
  output logic [`PARAM_W-1:0] cmd_param,
  output logic cmd_round_up
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_ABORT;
    cmd_stat = STAT_AVERAGE;
    cmd_sel_given = 1'b0;
    cmd_sel = 8'h00;
    cmd_param = 32'h0;
    cmd_round_up = 1'b0;
  end

  // Slot and two-digit channel range to a channel mask, slot 1 only
  function automatic logic [7:0] chan_mask(input int first, input int last);
    logic [7:0] m;
    m = 8'h00;
    for (int c = first; c <= last; c++) m[c-1] = 1'b1;
    return m;
  endfunction

  // Request held until the edge that sees ready high
  task automatic command(input cmd_op_t op, input stat_kind_t st, input logic given, input logic [7:0] sel,
                         input logic [31:0] prm, input logic up, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_stat = st;
    cmd_sel_given = given;
    cmd_sel = sel;
    cmd_param = prm;
    cmd_round_up = up;
    for (n = 0; n < 300 && !ok; n++) begin
      @(posedge clock);
      ok = cmd_ready_q === 1'b1;
    end
    #1;
    cmd_valid = 1'b0;
  endtask

  // Only allowed channel kinds are addressed unless a refusal is wanted
  task automatic query(input stat_kind_t st, input logic given, input logic [7:0] sel,
                       output logic [31:0] vals[$], output logic err, output logic ok);
    int n;
    logic done;
    vals = {};
    err = 1'b0;
    done = 1'b0;
    command(OP_QUERY, st, given, sel, 32'h0, 1'b0, ok);
    for (n = 0; n < 300 && ok && !done; n++) begin
      @(posedge clock);
      if (error_q === 1'b1) begin
        err = 1'b1;
        done = 1'b1;
      end
      if (resp_valid_q === 1'b1) begin
        if (resp_comma_q !== (vals.size() != 0)) ok = 1'b0;
        vals.push_back(resp_value_q);
        done = resp_last_q === 1'b1;
      end
    end
    for (n = 0; n < 50 && cmd_ready_q !== 1'b1; n++) @(posedge clock);
    ok = ok && done && cmd_ready_q === 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the scan statistics command unit.
// Assumes the host model drives commands and the bench drives readings.
`timescale 1ns/1ps
`default_nettype none
`include "scan_stats_params.svh"

module tb;
  import scan_stats_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, cmd_valid, cmd_sel_given, cmd_round_up, ok, err;
  cmd_op_t cmd_op;
  stat_kind_t cmd_stat;
  logic [7:0] cmd_sel, scan_list_q, channel_kind_ok = 8'hff;
  logic [31:0] cmd_param, param_q, v[$];
  logic meter_module_enable = 1'b1, meter_present = 1'b1, reading_valid = 1'b0;
  logic [2:0] reading_channel = 3'h0;
  logic signed [15:0] reading_value = 16'h0;
  logic cmd_ready_q, scan_running_q, resp_valid_q, resp_comma_q, resp_last_q, error_q;
  logic [5:0] stored_count_q;
  logic signed [31:0] resp_value_q;
  int n_fail = 0, comparisons = 0;
  logic [31:0] e0[6] = '{32'h4, 32'ha, 32'hffff_fffc, 32'he, 32'h7, 32'h3};
  logic [31:0] e2[6] = '{32'h64, 32'h64, 32'h64, 32'h0, 32'h0, 32'h1};

  always #5 clock = ~clock;

  scan_stats_unit scan_stats_unit_inst (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_stat(cmd_stat), .cmd_sel_given(cmd_sel_given), .cmd_sel(cmd_sel), .cmd_param(cmd_param),
    .cmd_round_up(cmd_round_up), .meter_module_enable(meter_module_enable), .meter_present(meter_present),
    .channel_kind_ok(channel_kind_ok), .reading_valid(reading_valid), .reading_channel(reading_channel),
    .reading_value(reading_value), .cmd_ready_q(cmd_ready_q), .scan_running_q(scan_running_q),
    .scan_list_q(scan_list_q), .param_q(param_q), .stored_count_q(stored_count_q), .resp_valid_q(resp_valid_q),
    .resp_value_q(resp_value_q), .resp_comma_q(resp_comma_q), .resp_last_q(resp_last_q), .error_q(error_q));

  host_model host_model_inst (.clock(clock), .cmd_ready_q(cmd_ready_q), .resp_valid_q(resp_valid_q),
    .resp_value_q(resp_value_q), .resp_comma_q(resp_comma_q), .resp_last_q(resp_last_q), .error_q(error_q),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_stat(cmd_stat), .cmd_sel_given(cmd_sel_given),
    .cmd_sel(cmd_sel), .cmd_param(cmd_param), .cmd_round_up(cmd_round_up));

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang_check(input string what);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s did not complete", $time, what);
      tally_and_finish();
    end
  endtask

  task automatic cmd(input cmd_op_t op, input logic [7:0] sel, input logic [31:0] prm, input logic up);
    host_model_inst.command(op, STAT_AVERAGE, 1'b1, sel, prm, up, ok);
    hang_check("command");
  endtask

  task automatic q(input stat_kind_t st, input logic given, input logic [7:0] sel, input logic [31:0] exp[$]);
    host_model_inst.query(st, given, sel, v, err, ok);
    hang_check("query");
    check(err, 1'b0, "query error");
    check(v.size(), exp.size(), "value count");
    for (int i = 0; i < exp.size() && i < v.size(); i++) check(v[i], exp[i], "query value");
  endtask

  task automatic read_in(input logic [2:0] ch, input logic signed [15:0] val);
    @(posedge clock);
    #1;
    reading_valid = 1'b1;
    reading_channel = ch;
    reading_value = val;
    @(posedge clock);
    #1;
    reading_valid = 1'b0;
  endtask

  task automatic t_reset();
    check({cmd_ready_q, scan_running_q, scan_list_q}, 32'h200, "idle after reset");
    check(param_q, 32'h2710, "factory parameter");
    check({stored_count_q, resp_valid_q, error_q}, 32'h0, "clear outputs");
  endtask

  task automatic t_snap();
    logic [31:0] req[5] = '{32'h1f4, 32'h1f4, 32'h3e8, 32'h7fff_ffff, 32'h5};
    logic [31:0] exp[5] = '{32'h3e8, 32'h64, 32'h3e8, 32'h05f5_e100, 32'ha};
    logic up[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      cmd(OP_SET_PARAM, 8'h00, req[i], up[i]);
      check(param_q, exp[i], "snapped parameter");
      check(error_q, 1'b0, "no error on snap");
    end
  endtask

  task automatic t_scan();
    cmd(OP_SET_SCAN_LIST, host_model_inst.chan_mask(1, 1) | host_model_inst.chan_mask(3, 3), 32'h0, 1'b0);
    cmd(OP_INITIATE, 8'h00, 32'h0, 1'b0);
    check(scan_running_q, 1'b1, "scan running");
    read_in(3'h0, 16'sd10);
    read_in(3'h2, 16'sd100);
    read_in(3'h0, -16'sd4);
    read_in(3'h0, 16'sd6);
    @(posedge clock);
    #1;
    check(stored_count_q, 6'h4, "stored readings");
    for (int k = 0; k < 6; k++) q(stat_kind_t'(k), 1'b1, 8'h05, '{e0[k], e2[k]});
    q(STAT_MAXIMUM, 1'b1, 8'h07, '{32'ha, 32'h0, 32'h64});
    q(STAT_COUNT, 1'b0, 8'h00, '{32'h3, 32'h1});
  endtask

  task automatic t_during();
    fork
      host_model_inst.query(STAT_COUNT, 1'b1, 8'h01, v, err, ok);
      read_in(3'h0, 16'sd2);
    join
    hang_check("query in scan");
    check(v.size(), 32'h1, "values in scan");
    check(v[0], 32'h4, "count in scan");
    check(scan_running_q, 1'b1, "scan kept running");
    q(STAT_COUNT, 1'b1, 8'h01, '{32'h4});
  endtask

  task automatic t_errors();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      #1;
      meter_module_enable = i != 0;
      meter_present = i != 1;
      channel_kind_ok = (i == 2) ? 8'hfb : 8'hff;
      host_model_inst.query(STAT_AVERAGE, 1'b1, 8'h05, v, err, ok);
      hang_check("refused query");
      check({err, v.size() == 0}, 2'b11, "refused query");
    end
    @(posedge clock);
    #1;
    {meter_module_enable, meter_present, channel_kind_ok} = 10'h3ff;
  endtask

  task automatic t_abort_clear();
    cmd(OP_ABORT, 8'h00, 32'h0, 1'b0);
    check(scan_running_q, 1'b0, "stopped by abort");
    read_in(3'h0, 16'sd50);
    check(stored_count_q, 6'h5, "readings kept after abort");
    q(STAT_COUNT, 1'b1, 8'h01, '{32'h4});
    cmd(OP_INITIATE, 8'h00, 32'h0, 1'b0);
    check(stored_count_q, 6'h0, "readings dropped at start");
    q(STAT_COUNT, 1'b0, 8'h00, '{32'h0, 32'h0});
    read_in(3'h0, 16'sd7);
    cmd(OP_STAT_CLEAR, 8'h00, 32'h0, 1'b0);
    q(STAT_MAXIMUM, 1'b1, 8'h01, '{32'h0});
    cmd(OP_SET_PARAM, 8'h00, 32'h64, 1'b1);
    read_in(3'h0, 16'sd7);
    cmd(OP_PRESET, 8'h00, 32'h0, 1'b0);
    check({scan_running_q, scan_list_q}, 32'h05, "preset keeps list");
    check(param_q, 32'h64, "preset keeps parameter");
    q(STAT_COUNT, 1'b1, 8'h01, '{32'h0});
    cmd(OP_INITIATE, 8'h00, 32'h0, 1'b0);
    read_in(3'h2, 16'sd9);
    cmd(OP_FACTORY_RESET, 8'h00, 32'h0, 1'b0);
    check({scan_running_q, scan_list_q}, 32'h0, "factory reset empties list");
    check(param_q, 32'h2710, "factory parameter restored");
    q(STAT_COUNT, 1'b1, 8'h04, '{32'h0});
  endtask

  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_snap();
    t_scan();
    t_during();
    t_errors();
    t_abort_clear();
    tally_and_finish();
  end
endmodule
`default_nettype wire
